// ==== rtl/rra_pkg.sv ====
// Purpose: Shared constants and types of the remote run answer-back sequencer
// Assumes: 10 MHz controller clock; all intervals measured in 10 ms ticks
// Notes: Times are kept in their own unit; tick counts derive from them

package rra_pkg;

    // ==========================================================
    // Clock and tick
    // ==========================================================
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = (TICK_MS * 1000000) / CLK_PERIOD_NS;

    // ==========================================================
    // Required times, in milliseconds
    // ==========================================================
    localparam int HOLD_MS = 300;
    localparam int SETTLE_MS = 5000;
    localparam int INIT_MS = 5000;
    localparam int DROP_MS = 2000;

    // ==========================================================
    // Tick counts: least times round up, longest times round down
    // ==========================================================
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] HOLD_TICKS = CNT_W'((HOLD_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [CNT_W-1:0] SETTLE_TICKS = CNT_W'(SETTLE_MS / TICK_MS);
    localparam logic [CNT_W-1:0] INIT_TICKS = CNT_W'(INIT_MS / TICK_MS);
    localparam logic [CNT_W-1:0] DROP_TICKS = CNT_W'(DROP_MS / TICK_MS);
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;

    // ==========================================================
    // Sequencer states
    // ==========================================================
    typedef enum logic [4:0] {
        ST_INIT = 5'h01,
        ST_IDLE = 5'h02,
        ST_DEFER = 5'h04,
        ST_RUN = 5'h08,
        ST_OUTAGE = 5'h10
    } rra_state_t;

endpackage

// ==== rtl/rra_tick.sv ====
// Purpose: Prescaler giving a one-cycle tick every CYCLES clocks
// Assumes: Synchronous active-low reset
// Notes: CYCLES may be shortened for simulation

`timescale 1ns/1ps
`default_nettype none

module rra_tick #(
    parameter int CYCLES = 100000
) (
    input wire logic clk,
    input wire logic nrst,
    output logic tick
);
    logic [16:0] div_r;
    logic [16:0] div_nxt;

    // ==========================================================
    // Divider
    // ==========================================================
    // Wraps at CYCLES-1 and flags the wrap
    always_comb begin
        if (div_r == 17'(CYCLES - 1)) begin
            div_nxt = 17'h00000;
        end else begin
            div_nxt = div_r + 17'h00001;
        end
    end

    assign tick = (div_r == 17'(CYCLES - 1));

    // Register the divider
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_r <= 17'h00000;
        end else begin
            div_r <= div_nxt;
        end
    end

endmodule

`default_nettype wire

// ==== rtl/rra_sequencer.sv ====
// Purpose: Remote run/halt sequencer with answer-back contacts for a compressor and two coolers
// Assumes: nrst marks full power removal; power_good low marks an input-power dropout
// Notes: All intervals counted in prescaled ticks; answers are registered
//
// Summary of operation
// - Normally the matching answer-back rises within 0.3 s of an accepted run or cooler command.
// - After power-up all remote inputs are ignored and outputs held off for 5 s.
// - A run request within 0.3 s of a stop defers start and answer-back for at most 5 s.
// - After a dropout shorter than 2 s the run answer-back is delayed up to 5 s before restart.
// - In pulse mode a running compressor resumes by itself when power returns within 2 s.
// - After recovery each cooler runs only if its own command is then asserted.
// - In level mode the compressor restarts on recovery whenever the run level is still asserted.
// - The mode is chosen from the first asserted run input after power-up and kept until power-off or a dropout of 2 s.
// - In pulse mode a run pulse over 0.3 s starts and latches; halt released over 0.3 s stops all.
// - In level mode the unit runs while the level is asserted and stops everything on release.
// - Cooler answers are withheld while the compressor is not running.

`timescale 1ns/1ps
`default_nettype none

module rra_sequencer
    import rra_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic power_good,
    input wire logic run_pulse,
    input wire logic halt_hold,
    input wire logic run_level,
    input wire logic cooler1_command,
    input wire logic cooler2_command,
    output logic compressor_answer,
    output logic cooler1_answer,
    output logic cooler2_answer,
    output logic mode_locked,
    output logic mode_level
);

    // ==========================================================
    // Declarations
    // ==========================================================
    rra_state_t st_r;
    rra_state_t st_nxt;
    logic tick;
    logic mode_valid_r, mode_valid_nxt;
    logic mode_level_r, mode_level_nxt;
    logic was_run_r, was_run_nxt;
    logic [CNT_W-1:0] tmr_r, tmr_nxt;
    logic [CNT_W-1:0] run_hold_r, run_hold_nxt;
    logic [CNT_W-1:0] halt_rel_r, halt_rel_nxt;
    logic [CNT_W-1:0] since_stop_r, since_stop_nxt;
    logic comp_ans_r, comp_ans_nxt;
    logic c1_ans_r, c1_ans_nxt;
    logic c2_ans_r, c2_ans_nxt;
    logic stop_req;
    logic pulse_start;
    logic want_start;
    logic resume;
    logic fast_restart;

    // Saturating tick-advance of an interval counter
    function automatic logic [CNT_W-1:0] tick_inc(input logic [CNT_W-1:0] v, input logic t);
        logic [CNT_W-1:0] r;
        r = v;
        if (t && (v != CNT_MAX)) begin
            r = v + 10'h001;
        end
        return r;
    endfunction

    // ==========================================================
    // Prescaler
    // ==========================================================
    // Tick that clocks every interval counter
    rra_tick #(
        .CYCLES(TICK_DIV)
    ) rra_tick_inst (
        .clk(clk),
        .nrst(nrst),
        .tick(tick)
    );

    // ==========================================================
    // Command decode
    // ==========================================================
    // Held-run start, held-release stop, level follow
    always_comb begin
        pulse_start = !mode_level_r && (run_hold_r > HOLD_TICKS) && halt_hold;
        stop_req = mode_level_r ? !run_level : (halt_rel_r > HOLD_TICKS);
        want_start = mode_valid_r && (mode_level_r ? run_level : pulse_start);
        resume = mode_valid_r && (mode_level_r ? run_level : was_run_r);
        fast_restart = (since_stop_r != CNT_MAX) && ({1'b0, since_stop_r} <=
            ({1'b0, HOLD_TICKS} + {1'b0, (mode_level_r ? CNT_ZERO : run_hold_r)}));
    end

    // ==========================================================
    // Sequencer next state
    // ==========================================================
    // Inputs are ignored during the power-up blackout
    always_comb begin
        st_nxt = st_r;
        mode_valid_nxt = mode_valid_r;
        mode_level_nxt = mode_level_r;
        was_run_nxt = was_run_r;
        tmr_nxt = tick_inc(tmr_r, tick);
        since_stop_nxt = tick_inc(since_stop_r, tick);
        run_hold_nxt = run_pulse ? tick_inc(run_hold_r, tick) : CNT_ZERO;
        halt_rel_nxt = !halt_hold ? tick_inc(halt_rel_r, tick) : CNT_ZERO;
        if (st_r == ST_INIT) begin
            run_hold_nxt = CNT_ZERO;
            halt_rel_nxt = CNT_ZERO;
            since_stop_nxt = CNT_MAX;
        end
        unique case (st_r)
            ST_INIT: begin
                if (tmr_r >= INIT_TICKS) begin
                    st_nxt = ST_IDLE;
                    tmr_nxt = CNT_ZERO;
                end
            end
            ST_IDLE: begin
                if (!mode_valid_r && run_pulse) begin
                    mode_valid_nxt = 1'b1;
                    mode_level_nxt = 1'b0;
                end else if (!mode_valid_r && run_level) begin
                    mode_valid_nxt = 1'b1;
                    mode_level_nxt = 1'b1;
                end
                if (want_start) begin
                    st_nxt = fast_restart ? ST_DEFER : ST_RUN;
                    tmr_nxt = CNT_ZERO;
                end
            end
            ST_DEFER: begin
                if (stop_req) begin
                    st_nxt = ST_IDLE;
                end else if (tmr_r >= SETTLE_TICKS) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_req) begin
                    st_nxt = ST_IDLE;
                    since_stop_nxt = CNT_ZERO;
                end
            end
            ST_OUTAGE: begin
                if (tmr_r >= DROP_TICKS) begin
                    st_nxt = ST_INIT;
                    mode_valid_nxt = 1'b0;
                    was_run_nxt = 1'b0;
                    tmr_nxt = CNT_ZERO;
                end else if (power_good) begin
                    st_nxt = resume ? ST_DEFER : ST_IDLE;
                    was_run_nxt = 1'b0;
                    tmr_nxt = CNT_ZERO;
                end
            end
        endcase
        // A dropout stops the unit and starts timing its length
        if (!power_good && (st_r != ST_INIT) && (st_r != ST_OUTAGE)) begin
            st_nxt = ST_OUTAGE;
            was_run_nxt = (st_r == ST_RUN);
            tmr_nxt = CNT_ZERO;
        end
    end

    // ==========================================================
    // Answer-back
    // ==========================================================
    // Answers follow the running state in the same cycle it is entered
    always_comb begin
        comp_ans_nxt = (st_nxt == ST_RUN);
        c1_ans_nxt = (st_nxt == ST_RUN) && cooler1_command;
        c2_ans_nxt = (st_nxt == ST_RUN) && cooler2_command;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // Register state, counters and answers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= ST_INIT;
            mode_valid_r <= 1'b0;
            mode_level_r <= 1'b0;
            was_run_r <= 1'b0;
            tmr_r <= CNT_ZERO;
            run_hold_r <= CNT_ZERO;
            halt_rel_r <= CNT_ZERO;
            since_stop_r <= CNT_MAX;
            comp_ans_r <= 1'b0;
            c1_ans_r <= 1'b0;
            c2_ans_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            mode_valid_r <= mode_valid_nxt;
            mode_level_r <= mode_level_nxt;
            was_run_r <= was_run_nxt;
            tmr_r <= tmr_nxt;
            run_hold_r <= run_hold_nxt;
            halt_rel_r <= halt_rel_nxt;
            since_stop_r <= since_stop_nxt;
            comp_ans_r <= comp_ans_nxt;
            c1_ans_r <= c1_ans_nxt;
            c2_ans_r <= c2_ans_nxt;
        end
    end

    assign compressor_answer = comp_ans_r;
    assign cooler1_answer = c1_ans_r;
    assign cooler2_answer = c2_ans_r;
    assign mode_locked = mode_valid_r;
    assign mode_level = mode_level_r;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_outage_end;
        (st_r == ST_OUTAGE) && power_good && (tmr_r < DROP_TICKS);
    endsequence

    property p_init_quiet;
        (st_r == ST_INIT) |-> !compressor_answer && !cooler1_answer && !cooler2_answer;
    endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("answer during blackout");

    property p_run_answer;
        (st_r == ST_RUN) |-> compressor_answer;
    endproperty
    a_run_answer: assert property (p_run_answer) else $error("running without answer");

    property p_defer_quiet;
        (st_r == ST_DEFER) |-> !compressor_answer && !cooler1_answer && !cooler2_answer;
    endproperty
    a_defer_quiet: assert property (p_defer_quiet) else $error("answer during deferral");

    property p_cooler_gate;
        (cooler1_answer || cooler2_answer) |-> compressor_answer;
    endproperty
    a_cooler_gate: assert property (p_cooler_gate) else $error("cooler answer while stopped");

    property p_cooler_follow;
        (st_r == ST_RUN) && cooler1_command && !stop_req && power_good |=> cooler1_answer;
    endproperty
    a_cooler_follow: assert property (p_cooler_follow) else $error("cooler answer missing");

    property p_fast_restart;
        (st_r == ST_IDLE) && want_start && fast_restart && power_good |=> (st_r == ST_DEFER);
    endproperty
    a_fast_restart: assert property (p_fast_restart) else $error("fast restart not deferred");

    property p_defer_bound;
        (st_r == ST_DEFER) |-> (tmr_r <= SETTLE_TICKS);
    endproperty
    a_defer_bound: assert property (p_defer_bound) else $error("deferral too long");

    property p_pulse_resume;
        s_outage_end ##0 (mode_valid_r && !mode_level_r && was_run_r) |=> (st_r == ST_DEFER);
    endproperty
    a_pulse_resume: assert property (p_pulse_resume) else $error("no auto resume");

    property p_level_resume;
        s_outage_end ##0 (mode_valid_r && mode_level_r && run_level) |=> (st_r == ST_DEFER);
    endproperty
    a_level_resume: assert property (p_level_resume) else $error("level restart missing");

    property p_mode_keep;
        mode_locked && (st_nxt != ST_INIT) |=> mode_locked && $stable(mode_level);
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("mode changed");

    property p_level_stop;
        (st_r == ST_RUN) && mode_level_r && !run_level |=> !compressor_answer ##0 !cooler1_answer;
    endproperty
    a_level_stop: assert property (p_level_stop) else $error("level release did not stop");

    property p_pulse_start;
        (st_r == ST_IDLE) && pulse_start && mode_valid_r && !fast_restart && power_good
            |=> compressor_answer;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("held pulse did not start");

endmodule

`default_nettype wire

// ==== verification/rra_ctl_model.sv ====
// Purpose: Equipment-side supervisor of the compressor answer-back
// Assumes: Same clock as the sequencer; expect_answer high while a run is awaited
// Notes: Fault is sticky until reset
`timescale 1ns/1ps
`default_nettype none

module rra_ctl_model #(
    parameter int TIMEOUT_CYC = 8000 // Eight seconds of waiting
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic expect_answer,
    input wire logic compressor_answer,
    output logic fault
);
    // ==========================================================
    // Supervision
    // ==========================================================
    int wait_r;

    // Count cycles spent waiting, then flag the compressor as faulty
    always_ff @(posedge clk) begin
        if (!nrst || !expect_answer || compressor_answer) begin
            wait_r <= 0;
        end else begin
            wait_r <= wait_r + 1;
        end
        if (!nrst) begin
            fault <= 1'b0;
        end else if (wait_r >= TIMEOUT_CYC) begin
            fault <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// ==== verification/tb_remote_run_answerback_sequencer.sv ====
// Purpose: Self-checking bench of the remote run answer-back sequencer
// Assumes: Tick shortened to 10 clocks, so a second is 1000 cycles
// Notes: One task per scenario; level mode first, pulse mode after a second reset
`timescale 1ns/1ps
`default_nettype none

module tb_remote_run_answerback_sequencer import rra_pkg::*;;
    // ==========================================================
    // Timing figures
    // ==========================================================
    localparam int DIV = 10;
    localparam int INIT_CYC = (int'(INIT_TICKS) + 1) * DIV;
    localparam int SET_CYC = int'(SETTLE_TICKS) * DIV;
    localparam int HOLD_CYC = int'(HOLD_TICKS) * DIV;
    localparam int DROP_CYC = int'(DROP_TICKS) * DIV;
    localparam int LIMIT = 60000;

    logic clk = 1'b0, nrst, power_good, run_pulse, halt_hold, run_level;
    logic cooler1_command, cooler2_command, compressor_answer, cooler1_answer, cooler2_answer;
    logic mode_locked, mode_level, expect_answer, fault;
    int bad_count = 0, n_tests = 0, cyc = 0;

    rra_sequencer #(.TICK_DIV(DIV)) rra_sequencer_inst (.clk(clk), .nrst(nrst), .power_good(power_good),
        .run_pulse(run_pulse), .halt_hold(halt_hold), .run_level(run_level),
        .cooler1_command(cooler1_command), .cooler2_command(cooler2_command),
        .compressor_answer(compressor_answer), .cooler1_answer(cooler1_answer),
        .cooler2_answer(cooler2_answer), .mode_locked(mode_locked), .mode_level(mode_level));

    rra_ctl_model #(.TIMEOUT_CYC(80 * 10 * DIV)) rra_ctl_model_inst (.clk(clk), .nrst(nrst),
        .expect_answer(expect_answer), .compressor_answer(compressor_answer), .fault(fault));

    // Clock and hang guard
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            finish_test();
        end
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input string what, input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_comp(input logic exp, input int limit);
        int k;
        k = 0;
        @(negedge clk);
        while (compressor_answer !== exp && k < limit) begin
            @(negedge clk);
            k++;
        end
        check("compressor_answer", compressor_answer, exp);
    endtask

    task automatic finish_test;
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Commands during power-up are ignored, then level mode starts
    task automatic t_blackout;
        run_level <= 1'b1;
        cooler2_command <= 1'b1;
        cyc_wait(INIT_CYC - 150);
        @(negedge clk);
        check("compressor_answer", compressor_answer, 1'b0);
        check("mode_locked", mode_locked, 1'b0);
        wait_comp(1'b1, 150 + HOLD_CYC);
        check("mode_level", mode_level, 1'b1);
        check("mode_locked", mode_locked, 1'b1);
        @(negedge clk);
        check("cooler2_answer", cooler2_answer, 1'b1);
    endtask

    // Cooler follows its command; releasing the level stops all
    task automatic t_level_stop;
        @(posedge clk);
        cooler1_command <= 1'b1;
        cyc_wait(2);
        @(negedge clk);
        check("cooler1_answer", cooler1_answer, 1'b1);
        @(posedge clk);
        run_level <= 1'b0;
        cyc_wait(2);
        @(negedge clk);
        check("compressor_answer", compressor_answer, 1'b0);
        check("cooler2_answer", cooler2_answer, 1'b0);
        cyc_wait(2);
        @(negedge clk);
        check("cooler1_answer", cooler1_answer, 1'b0);
    endtask

    // Restart right after a stop is deferred with answers held off
    task automatic t_defer;
        @(posedge clk);
        run_level <= 1'b1;
        expect_answer <= 1'b1;
        cyc_wait(SET_CYC - 1000);
        @(negedge clk);
        check("compressor_answer", compressor_answer, 1'b0);
        check("cooler1_answer", cooler1_answer, 1'b0);
        wait_comp(1'b1, 1000 + HOLD_CYC);
        @(negedge clk);
        check("cooler1_answer", cooler1_answer, 1'b1);
    endtask

    // Short dropout: answers drop, then delayed restart with the command held
    task automatic t_dropout;
        @(posedge clk);
        power_good <= 1'b0;
        cyc_wait(2);
        @(negedge clk);
        check("compressor_answer", compressor_answer, 1'b0);
        cyc_wait(1000);
        power_good <= 1'b1;
        cyc_wait(SET_CYC - 1000);
        @(negedge clk);
        check("compressor_answer", compressor_answer, 1'b0);
        wait_comp(1'b1, 1000 + HOLD_CYC);
    endtask

    // Pulse mode: short pulse refused, level ignored, long pulse latches
    task automatic t_pulse;
        @(posedge clk);
        nrst <= 1'b0;
        run_level <= 1'b0;
        expect_answer <= 1'b0;
        {cooler1_command, cooler2_command} <= 2'h0;
        cyc_wait(16);
        nrst <= 1'b1;
        cyc_wait(INIT_CYC + 20);
        run_pulse <= 1'b1; // Short pulse
        cyc_wait(HOLD_CYC - 100);
        run_pulse <= 1'b0;
        cyc_wait(50);
        @(negedge clk);
        check("compressor_answer", compressor_answer, 1'b0);
        check("mode_level", mode_level, 1'b0);
        @(posedge clk);
        run_level <= 1'b1;
        run_pulse <= 1'b1; // Held past the minimum
        cyc_wait(HOLD_CYC - 100);
        @(negedge clk);
        check("compressor_answer", compressor_answer, 1'b0);
        cyc_wait(150);
        run_pulse <= 1'b0;
        run_level <= 1'b0;
        cooler1_command <= 1'b1;
        wait_comp(1'b1, 20);
        cyc_wait(2);
        @(negedge clk);
        check("cooler1_answer", cooler1_answer, 1'b1);
    endtask

    // Pulse mode resumes after a dropout; coolers follow current commands
    task automatic t_resume;
        @(posedge clk);
        power_good <= 1'b0;
        expect_answer <= 1'b1;
        cooler1_command <= 1'b0;
        cooler2_command <= 1'b1;
        cyc_wait(1000);
        power_good <= 1'b1;
        wait_comp(1'b1, SET_CYC + HOLD_CYC);
        cyc_wait(2);
        @(negedge clk);
        check("cooler1_answer", cooler1_answer, 1'b0);
        check("cooler2_answer", cooler2_answer, 1'b1);
        check("fault", fault, 1'b0);
    endtask

    // Halt released briefly keeps running; held longer stops all
    task automatic t_halt;
        @(posedge clk);
        halt_hold <= 1'b0;
        cyc_wait(HOLD_CYC - 100);
        halt_hold <= 1'b1;
        cyc_wait(5);
        @(negedge clk);
        check("compressor_answer", compressor_answer, 1'b1);
        @(posedge clk);
        halt_hold <= 1'b0;
        cyc_wait(HOLD_CYC + 50);
        @(negedge clk);
        check("compressor_answer", compressor_answer, 1'b0);
        check("cooler2_answer", cooler2_answer, 1'b0);
    endtask

    // Dropout past the short limit counts as power removal: mode cleared, new blackout
    task automatic t_long_drop;
        @(posedge clk);
        power_good <= 1'b0;
        cyc_wait(DROP_CYC + 100);
        @(negedge clk);
        check("mode_locked", mode_locked, 1'b0);
        check("compressor_answer", compressor_answer, 1'b0);
        @(posedge clk);
        power_good <= 1'b1;
        run_level <= 1'b1;
        cyc_wait(100);
        @(negedge clk);
        check("mode_locked", mode_locked, 1'b0);
        check("compressor_answer", compressor_answer, 1'b0);
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {nrst, run_pulse, run_level, cooler1_command, cooler2_command, expect_answer} = 6'h00;
        {power_good, halt_hold} = 2'h3;
        cyc_wait(16);
        nrst <= 1'b1;
        t_blackout();
        t_level_stop();
        t_defer();
        t_dropout();
        t_pulse();
        t_resume();
        t_halt();
        t_long_drop();
        finish_test();
    end
endmodule

`default_nettype wire
